// ---- fiap_device.sv ----
`timescale 1ns/1ps
`include "fiap_map.svh"
// Summary of operation
// - commands ignored unless programming enable set
// - irq enable routes completion to irq1
// - decode chip, sector and block erase
// - decode byte program and byte verify
// - decode three lock-bit program commands
// - decode config cell and clock double
// - reserved codes do no flash operation
// - verify takes one cycle, no irq
// - address built from low and high bytes
// - data mailbox holds written or read byte
// - status top bits show inverse lock bits
// - status bit 3 shows double speed
// - status bit 2 busy, reset zero
// - config bit 0 selects block map
module fiap_device #(
  parameter int             ADDR_W        = 16,
  parameter logic [15:0]    ERASE_CYCLES  = `FIAP_ERASE_CYCLES,
  parameter logic [15:0]    PROG_CYCLES   = `FIAP_PROG_CYCLES
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  fiap_if.device      bus,
  input  wire logic   i_ext_irq1_pin_n,
  input  wire logic [7:0] i_flash_rdata,
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [7:0]  o_flash_wdata,
  output logic [6:0]  o_flash_op,
  output logic        o_flash_start,
  output logic        o_block_map_select,
  output logic        o_software_reset_request
);
  typedef struct packed {
    fiap_pkg::fiap_state_type state;
    logic [7:0]  cfg;
    logic [7:0]  cmd;
    logic [7:0]  addr_lo;
    logic [7:0]  addr_hi;
    logic [7:0]  data;
    logic [2:0]  lock;
    logic        dbl;
    logic [15:0] cnt;
    logic        done_evt;
    logic        start;
    logic [7:0]  rdata;
    logic [1:0]  pin_sync;
    logic        pin_prev;
  } fiap_dev_type;

  fiap_dev_type cur_ff;
  fiap_dev_type nxt_cur;
  logic         valid_code;
  logic         busy;
  logic [15:0]  op_len;
  logic [7:0]   status;

  assign busy = (cur_ff.state != fiap_pkg::FIAP_IDLE);
  assign status = {~cur_ff.lock[0], ~cur_ff.lock[1], ~cur_ff.lock[2],
                   1'b0, cur_ff.dbl, busy, 2'b00};

  always_comb begin
    unique case (bus.wdata[6:0])
      `FIAP_CODE_CHIP_ERASE,
      `FIAP_CODE_SECTOR_ERASE,
      `FIAP_CODE_BLOCK_ERASE: begin
        valid_code = 1'b1;
        op_len = ERASE_CYCLES;
      end
      `FIAP_CODE_VERIFY: begin
        valid_code = 1'b1;
        op_len = `FIAP_VERIFY_CYCLES;
      end
      `FIAP_CODE_PROGRAM,
      `FIAP_CODE_LOCK1, `FIAP_CODE_LOCK2, `FIAP_CODE_LOCK3,
      `FIAP_CODE_CFG_CELL, `FIAP_CODE_CLK_DOUBLE: begin
        valid_code = 1'b1;
        op_len = PROG_CYCLES;
      end
      default: begin
        valid_code = 1'b0;
        op_len = 16'h0000;
      end
    endcase
  end

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.start = 1'b0;
    nxt_cur.done_evt = 1'b0;
    nxt_cur.pin_sync = {cur_ff.pin_sync[0], i_ext_irq1_pin_n};
    nxt_cur.pin_prev = cur_ff.pin_sync[1];
    nxt_cur.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        `FIAP_OFS_CONFIG:  nxt_cur.rdata = cur_ff.cfg;
        `FIAP_OFS_COMMAND: nxt_cur.rdata = cur_ff.cmd;
        `FIAP_OFS_ADDR_LO: nxt_cur.rdata = cur_ff.addr_lo;
        `FIAP_OFS_ADDR_HI: nxt_cur.rdata = cur_ff.addr_hi;
        `FIAP_OFS_DATA:    nxt_cur.rdata = cur_ff.data;
        `FIAP_OFS_STATUS:  nxt_cur.rdata = status;
        default:           nxt_cur.rdata = 8'h00;
      endcase
    end
    unique case (cur_ff.state)
      fiap_pkg::FIAP_IDLE: ;
      fiap_pkg::FIAP_BUSY: begin
        if (cur_ff.cnt <= 16'd1) begin
          nxt_cur.state = fiap_pkg::FIAP_DONE;
        end else begin
          nxt_cur.cnt = cur_ff.cnt - 16'd1;
        end
      end
      fiap_pkg::FIAP_DONE: begin
        nxt_cur.state = fiap_pkg::FIAP_IDLE;
        unique case (cur_ff.cmd[6:0])
          `FIAP_CODE_VERIFY:     nxt_cur.data = i_flash_rdata;
          `FIAP_CODE_LOCK1:      nxt_cur.lock[0] = 1'b1;
          `FIAP_CODE_LOCK2:      nxt_cur.lock[1] = 1'b1;
          `FIAP_CODE_LOCK3:      nxt_cur.lock[2] = 1'b1;
          `FIAP_CODE_CLK_DOUBLE: nxt_cur.dbl = 1'b1;
          default: ;
        endcase
        nxt_cur.done_evt = (cur_ff.cmd[6:0] != `FIAP_CODE_VERIFY);
      end
      default: nxt_cur.state = fiap_pkg::FIAP_IDLE;
    endcase
    if (bus.wr) begin
      unique case (bus.addr)
        `FIAP_OFS_CONFIG:
          nxt_cur.cfg = bus.wdata & `FIAP_CFG_WMASK;
        `FIAP_OFS_COMMAND: begin
          nxt_cur.cmd[`FIAP_CMD_IRQ_EN] = bus.wdata[`FIAP_CMD_IRQ_EN];
          // a command while busy is dropped, not queued
          if (cur_ff.cfg[`FIAP_CFG_PROG_EN] && valid_code && !busy) begin
            nxt_cur.cmd[6:0] = bus.wdata[6:0];
            nxt_cur.cnt = op_len;
            nxt_cur.state = fiap_pkg::FIAP_BUSY;
            nxt_cur.start = 1'b1;
          end
        end
        `FIAP_OFS_ADDR_LO: nxt_cur.addr_lo = bus.wdata;
        `FIAP_OFS_ADDR_HI: nxt_cur.addr_hi = bus.wdata;
        `FIAP_OFS_DATA:    nxt_cur.data = bus.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_ff <= '0;
      cur_ff.state <= fiap_pkg::FIAP_IDLE;
      cur_ff.pin_sync <= 2'b11;
      cur_ff.pin_prev <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // pin edge is only seen when completion does not own the line
  assign bus.irq1 = cur_ff.cmd[`FIAP_CMD_IRQ_EN] ? cur_ff.done_evt
                  : (cur_ff.pin_prev & ~cur_ff.pin_sync[1]);
  assign bus.rdata = cur_ff.rdata;
  assign o_flash_addr = ADDR_W'({cur_ff.addr_hi, cur_ff.addr_lo});
  assign o_flash_wdata = cur_ff.data;
  assign o_flash_op = cur_ff.cmd[6:0];
  assign o_flash_start = cur_ff.start;
  assign o_block_map_select = cur_ff.cfg[`FIAP_CFG_BLOCK_SEL];
  assign o_software_reset_request = cur_ff.cfg[`FIAP_CFG_SW_RESET];
endmodule

// ---- fiap_host.sv ----
`timescale 1ns/1ps
`include "fiap_map.svh"
module fiap_host (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  fiap_if.host             bus,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [15:0]      o_reg_rdata
);
  typedef struct packed {
    fiap_pkg::fiap_host_state_type state;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  rd_data;
    logic [1:0]  step;
    logic        irq_seen;
    logic        wait_rd;
    logic [7:0]  baddr;
    logic [7:0]  bwdata;
    logic        bwr;
    logic        brd;
    logic [15:0] rdata;
  } fiap_host_data_type;

  fiap_host_data_type cur_ff;
  fiap_host_data_type nxt_cur;
  logic               busy;

  assign busy = (cur_ff.state != fiap_pkg::FIAP_H_IDLE);

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.bwr = 1'b0;
    nxt_cur.brd = 1'b0;
    nxt_cur.wait_rd = 1'b0;
    nxt_cur.rdata = 16'h0000;
    if (bus.irq1) nxt_cur.irq_seen = 1'b1;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `FIAP_HOST_OFS_CMD:    nxt_cur.rdata = {8'h00, cur_ff.cmd};
        `FIAP_HOST_OFS_ADDR:   nxt_cur.rdata = cur_ff.addr;
        `FIAP_HOST_OFS_DATA:   nxt_cur.rdata = {8'h00, cur_ff.rd_data};
        `FIAP_HOST_OFS_STATUS:
          nxt_cur.rdata = {14'h0000, cur_ff.irq_seen, busy};
        default:               nxt_cur.rdata = 16'h0000;
      endcase
    end
    unique case (cur_ff.state)
      fiap_pkg::FIAP_H_IDLE: begin
        if (i_reg_wr) begin
          unique case (i_reg_addr)
            `FIAP_HOST_OFS_CMD: begin
              nxt_cur.cmd = i_reg_wdata[7:0];
              nxt_cur.state = fiap_pkg::FIAP_H_WRITE;
              nxt_cur.step = 2'd0;
            end
            `FIAP_HOST_OFS_ADDR: nxt_cur.addr = i_reg_wdata;
            `FIAP_HOST_OFS_DATA: nxt_cur.data = i_reg_wdata[7:0];
            `FIAP_HOST_OFS_STATUS: nxt_cur.irq_seen = bus.irq1;
            `FIAP_HOST_OFS_CFG: begin
              // one pass-through write, otherwise nothing could enable
              nxt_cur.bwr = 1'b1;
              nxt_cur.baddr = `FIAP_OFS_CONFIG;
              nxt_cur.bwdata = i_reg_wdata[7:0];
            end
            default: ;
          endcase
        end
      end
      fiap_pkg::FIAP_H_WRITE: begin
        // mailboxes first, command last, so it sees stable operands
        nxt_cur.bwr = 1'b1;
        nxt_cur.step = cur_ff.step + 2'd1;
        unique case (cur_ff.step)
          2'd0: begin
            nxt_cur.baddr = `FIAP_OFS_ADDR_LO;
            nxt_cur.bwdata = cur_ff.addr[7:0];
          end
          2'd1: begin
            nxt_cur.baddr = `FIAP_OFS_ADDR_HI;
            nxt_cur.bwdata = cur_ff.addr[15:8];
          end
          2'd2: begin
            nxt_cur.baddr = `FIAP_OFS_DATA;
            nxt_cur.bwdata = cur_ff.data;
          end
          default: begin
            nxt_cur.baddr = `FIAP_OFS_COMMAND;
            nxt_cur.bwdata = cur_ff.cmd;
            nxt_cur.state = fiap_pkg::FIAP_H_POLL;
          end
        endcase
      end
      fiap_pkg::FIAP_H_POLL: begin
        // waits on busy before any further access; status data stand
        // only in the cycle after the read strobe
        if (cur_ff.brd) begin
          nxt_cur.wait_rd = 1'b1;
        end else if (cur_ff.wait_rd && !bus.rdata[`FIAP_ST_BUSY]) begin
          nxt_cur.state = fiap_pkg::FIAP_H_FETCH;
          nxt_cur.brd = 1'b1;
          nxt_cur.baddr = `FIAP_OFS_DATA;
        end else begin
          nxt_cur.brd = 1'b1;
          nxt_cur.baddr = `FIAP_OFS_STATUS;
        end
      end
      fiap_pkg::FIAP_H_FETCH: begin
        if (!cur_ff.brd) begin
          nxt_cur.rd_data = bus.rdata;
          nxt_cur.state = fiap_pkg::FIAP_H_IDLE;
        end
      end
      default: nxt_cur.state = fiap_pkg::FIAP_H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cur_ff <= '0;
      cur_ff.state <= fiap_pkg::FIAP_H_IDLE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign bus.addr = cur_ff.baddr;
  assign bus.wdata = cur_ff.bwdata;
  assign bus.wr = cur_ff.bwr;
  assign bus.rd = cur_ff.brd;
  assign o_reg_rdata = cur_ff.rdata;
endmodule

// ---- fiap_if.sv ----
`timescale 1ns/1ps
interface fiap_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       irq1;
  modport device (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output irq1
  );
  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  irq1
  );
endinterface

// ---- fiap_map.svh ----
`ifndef FIAP_MAP_SVH
`define FIAP_MAP_SVH
// register offsets as seen by the core
`define FIAP_OFS_CONFIG    8'hb1
`define FIAP_OFS_COMMAND   8'hb2
`define FIAP_OFS_ADDR_LO   8'hb3
`define FIAP_OFS_ADDR_HI   8'hb4
`define FIAP_OFS_DATA      8'hb5
`define FIAP_OFS_STATUS    8'hb6
// config fields
`define FIAP_CFG_PROG_EN   6
`define FIAP_CFG_SW_RESET  1
`define FIAP_CFG_BLOCK_SEL 0
`define FIAP_CFG_WMASK     8'h43
// command fields
`define FIAP_CMD_IRQ_EN    7
// status fields
`define FIAP_ST_LOCK1_INV  7
`define FIAP_ST_LOCK2_INV  6
`define FIAP_ST_LOCK3_INV  5
`define FIAP_ST_DOUBLE     3
`define FIAP_ST_BUSY       2
// command codes
`define FIAP_CODE_CHIP_ERASE   7'h01
`define FIAP_CODE_SECTOR_ERASE 7'h0b
`define FIAP_CODE_BLOCK_ERASE  7'h0d
`define FIAP_CODE_VERIFY       7'h0c
`define FIAP_CODE_PROGRAM      7'h0e
`define FIAP_CODE_LOCK1        7'h0f
`define FIAP_CODE_LOCK2        7'h03
`define FIAP_CODE_LOCK3        7'h05
`define FIAP_CODE_CFG_CELL     7'h09
`define FIAP_CODE_CLK_DOUBLE   7'h08
// controller-side register offsets
`define FIAP_HOST_OFS_CMD      4'h0
`define FIAP_HOST_OFS_ADDR     4'h1
`define FIAP_HOST_OFS_DATA     4'h2
`define FIAP_HOST_OFS_STATUS   4'h3
`define FIAP_HOST_OFS_CFG      4'h4
// default busy durations in core clocks
`define FIAP_ERASE_CYCLES      16'd64
`define FIAP_PROG_CYCLES       16'd16
`define FIAP_VERIFY_CYCLES     16'd1
`endif

// ---- fiap_pkg.sv ----
package fiap_pkg;
  typedef enum logic [2:0] {
    FIAP_IDLE = 3'b001,
    FIAP_BUSY = 3'b010,
    FIAP_DONE = 3'b100
  } fiap_state_type;
  typedef enum logic [3:0] {
    FIAP_H_IDLE  = 4'b0001,
    FIAP_H_WRITE = 4'b0010,
    FIAP_H_POLL  = 4'b0100,
    FIAP_H_FETCH = 4'b1000
  } fiap_host_state_type;
endpackage

// ---- fiap_properties.sv ----
`timescale 1ns/1ps
module fiap_properties (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       irq1
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic en_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_ff <= 1'b0;
    end else if (wr && addr == 8'hb1) begin
      en_ff <= wdata[6];
    end
  end
  one_strobe_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its slot");
  status_fields_a: assert property (rd && addr == 8'hb6 |=>
    rdata[4] == 1'b0 && rdata[1:0] == 2'b00)
    else $error("unused status bits set");
  host_order_a: assert property (wr && addr == 8'hb3 |=>
    (wr && addr == 8'hb4) ##1 (wr && addr == 8'hb5) ##1 (wr && addr == 8'hb2))
    else $error("mailbox load order broken");
  poll_after_a: assert property (wr && addr == 8'hb2 |->
    ##[1:8] (rd && addr == 8'hb6))
    else $error("no status poll after command");
  irq_pulse_a: assert property (irq1 |=> !irq1)
    else $error("completion pulse too long");
  busy_off_a: assert property (rd && addr == 8'hb6 && !en_ff |=>
    !rdata[2])
    else $error("busy while programming disabled");
  lock_kept_a: assert property (rd && addr == 8'hb6 && !en_ff |=>
    rdata[7:5] == 3'b111)
    else $error("lock bit programmed while disabled");
endmodule

// ---- flash_iap_command_port_tb.sv ----
`timescale 1ns/1ps
module flash_iap_command_port_tb;
  logic        i_clk, i_rst, pin_n, reg_wr, reg_rd, start_a, start_b, block_map_select_b;
  logic        swr_b;
  logic [7:0]  flash_rd, v, wd_b;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, addr_a, addr_b, w;
  logic [6:0]  op_b;
  logic [6:0]  codes [10] = '{7'h01, 7'h0b, 7'h0d, 7'h0c, 7'h0e,
                              7'h0f, 7'h03, 7'h05, 7'h09, 7'h08};
  int          mismatches = 0, n_tests = 0, starts_a = 0, starts_b = 0;
  int          irqs = 0;
  fiap_if if_a ();
  fiap_if if_b ();
  fiap_host u_fiap_host (.i_clk(i_clk), .i_rst(i_rst), .bus(if_a.host),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));
  // short busy counts keep the run brief
  fiap_device #(.ERASE_CYCLES(16'd8), .PROG_CYCLES(16'd8)) u_fiap_device (
    .i_clk(i_clk), .i_rst(i_rst), .bus(if_a.device),
    .i_ext_irq1_pin_n(1'b1), .i_flash_rdata(flash_rd),
    .o_flash_addr(addr_a), .o_flash_wdata(), .o_flash_op(),
    .o_flash_start(start_a), .o_block_map_select(),
    .o_software_reset_request());
  // second device gives direct register access for config and irq
  fiap_device #(.ERASE_CYCLES(16'd8), .PROG_CYCLES(16'd8)) u_fiap_device_b (
    .i_clk(i_clk), .i_rst(i_rst), .bus(if_b.device),
    .i_ext_irq1_pin_n(pin_n), .i_flash_rdata(flash_rd),
    .o_flash_addr(addr_b), .o_flash_wdata(wd_b), .o_flash_op(op_b),
    .o_flash_start(start_b), .o_block_map_select(block_map_select_b),
    .o_software_reset_request(swr_b));
  fiap_properties u_fiap_properties (.i_clk(i_clk), .i_rst(i_rst),
    .addr(if_a.addr), .wdata(if_a.wdata), .wr(if_a.wr), .rd(if_a.rd),
    .rdata(if_a.rdata), .irq1(if_a.irq1));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (start_a === 1'b1) starts_a++;
    if (start_b === 1'b1) starts_b++;
    if (if_b.irq1 === 1'b1) irqs++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    if_b.wr <= 1'b1;
    if_b.addr <= a;
    if_b.wdata <= d;
    @(posedge i_clk);
    if_b.wr <= 1'b0;
  endtask
  task automatic dr(input logic [7:0] a);
    @(posedge i_clk);
    if_b.rd <= 1'b1;
    if_b.addr <= a;
    @(posedge i_clk);
    if_b.rd <= 1'b0;
    #1 v = if_b.rdata;
  endtask
  task automatic hw(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic hr(input logic [3:0] a);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1 w = reg_rdata;
  endtask
  task automatic poll(input bit host);
    int k;
    for (k = 0; k < 200; k++) begin
      if (host) hr(4'h3);
      else dr(8'hb6);
      if ((host ? w[0] : v[2]) === 1'b0) break;
    end
    if (k == 200) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic pin_pulse;
    pin_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    pin_n <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask
  initial begin
    {i_rst, pin_n, flash_rd, reg_addr, reg_wdata} = {2'b11, 8'h5a, 20'h0};
    {reg_wr, reg_rd, if_b.addr, if_b.wdata, if_b.wr, if_b.rd} = '0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    dr(8'hb1);
    chk(v, 8'h00);
    dr(8'hb6);
    chk(v, 8'he0);
    dw(8'hb6, 8'hff);
    dr(8'hb6);
    chk(v, 8'he0);
    dr(8'hb0);
    chk(v, 8'h00);
    dw(8'hb2, 8'h0e);
    dr(8'hb6);
    chk(v, 8'he0);
    chk(starts_b, 0);
    dw(8'hb1, 8'h41);
    dr(8'hb1);
    chk(v, 8'h41);
    chk(block_map_select_b, 1'b1);
    dw(8'hb1, 8'hff);
    dr(8'hb1);
    chk(v, 8'h43);
    chk(swr_b, 1'b1);
    dw(8'hb1, 8'h41);
    dr(8'hb1);
    chk(swr_b, 1'b0);
    dw(8'hb3, 8'h34);
    dw(8'hb4, 8'h12);
    dw(8'hb5, 8'ha5);
    dw(8'hb2, 8'h0e);
    dr(8'hb6);
    chk(v[2], 1'b1);
    // a command while busy must be dropped
    dw(8'hb2, 8'h01);
    poll(0);
    chk(op_b, 7'h0e);
    chk(addr_b, 16'h1234);
    chk(wd_b, 8'ha5);
    chk(starts_b, 1);
    for (int i = 0; i < 10; i++) begin
      dw(8'hb2, {1'b0, codes[i]});
      poll(0);
      chk(op_b, codes[i]);
    end
    dr(8'hb6);
    chk(v, 8'h08);
    dw(8'hb2, 8'h02);
    poll(0);
    chk(op_b, 7'h08);
    chk(starts_b, 11);
    pin_pulse();
    chk(irqs, 1);
    dw(8'hb2, 8'h8e);
    poll(0);
    repeat (3) @(posedge i_clk);
    chk(irqs, 2);
    pin_pulse();
    chk(irqs, 2);
    flash_rd <= 8'hc3;
    dw(8'hb2, 8'h8c);
    poll(0);
    dr(8'hb5);
    chk(v, 8'hc3);
    repeat (3) @(posedge i_clk);
    chk(irqs, 2);
    hw(4'h1, 16'h5678);
    hw(4'h2, 16'h00c3);
    hw(4'h0, 16'h000e);
    poll(1);
    chk(addr_a, 16'h5678);
    chk(starts_a, 0);
    hw(4'h4, 16'h0040);
    hw(4'h0, 16'h008c);
    poll(1);
    chk(w, 16'h0000);
    hr(4'h2);
    chk(w, 16'h00c3);
    chk(starts_a, 1);
    hw(4'h0, 16'h008e);
    poll(1);
    chk(w, 16'h0002);
    chk(starts_a, 2);
    hw(4'h3, 16'h0000);
    hr(4'h3);
    chk(w, 16'h0000);
    finish_test();
  end
endmodule
